// File: src/sbc_bank_tracker.v
// four-bank command decoder and state tracker
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_bank_tracker #(
    parameter [7:0] T_RP  = `SBC_T_RP,
    parameter [7:0] T_RCD = `SBC_T_RCD,
    parameter [7:0] T_RFC = `SBC_T_RFC,
    parameter [7:0] T_MRD = `SBC_T_MRD,
    parameter [7:0] T_WR  = `SBC_T_WR,
    parameter [7:0] BL    = `SBC_BL,
    parameter [7:0] CL    = `SBC_CL
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // command pins
    input  wire        clock_enable_pin,
    input  wire        chip_select_n,
    input  wire        row_strobe_n,
    input  wire        column_strobe_n,
    input  wire        write_strobe_n,
    input  wire        bank_select_bit0,
    input  wire        bank_select_bit1,
    input  wire        auto_precharge_address_bit,
    // status
    output wire [11:0] bank_state,
    output wire [1:0]  device_state,
    output wire        all_idle,
    output wire        cmd_taken
);
    // ************************************************
    // pin synchronisers
    // ************************************************
    reg [7:0] pin_s1_ff;
    reg [7:0] pin_s2_ff;
    reg       cke_prev_ff;
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_ff   <= 8'h1F;
            pin_s2_ff   <= 8'h1F;
            cke_prev_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff   <= {auto_precharge_address_bit, bank_select_bit1, bank_select_bit0,
                            clock_enable_pin, chip_select_n, row_strobe_n,
                            column_strobe_n, write_strobe_n};
            pin_s2_ff   <= pin_s1_ff;
            cke_prev_ff <= pin_s2_ff[4];
        end
    end

    // ************************************************
    // command decode
    // ************************************************
    wire [3:0] cmd    = pin_s2_ff[3:0];
    wire       cke_ok = cke_prev_ff & pin_s2_ff[4];
    wire [1:0] bsel   = pin_s2_ff[6:5];
    wire       ap     = pin_s2_ff[7];
    reg  [1:0] dev_ff;
    reg  [7:0] dev_cnt_ff;
    // a command only counts when selected, enabled and no device-wide op runs
    wire       valid  = cke_ok & ~cmd[3] & (cmd[2:0] != 3'h7) & (dev_ff == `SBC_DV_NORM);
    wire       is_act = valid & (cmd == `SBC_CMD_ACT);
    wire       is_rd  = valid & (cmd == `SBC_CMD_READ);
    wire       is_wr  = valid & (cmd == `SBC_CMD_WRITE);
    wire       is_pre = valid & (cmd == `SBC_CMD_PRE);
    wire       is_bst = valid & (cmd == `SBC_CMD_BST);
    wire       is_ref = valid & (cmd == `SBC_CMD_AREF);
    wire       is_lmr = valid & (cmd == `SBC_CMD_LMR);
    wire [7:0] burst_cyc = BL >> 1;
    reg  [1:0] last_rd_ff;                                   // bank of latest read
    wire [3:0] idle_v;
    wire [3:0] acc_v;                                        // per-bank accept
    reg        taken;

    // ************************************************
    // per-bank state machines
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_bank
            localparam [31:0] BANK_W = g;
            wire       sel = (bsel == BANK_W[1:0]);
            reg  [2:0] st_ff;
            reg  [7:0] cnt_ff;
            reg  [2:0] nxt_st;
            reg  [7:0] nxt_cnt;
            reg        acc;
            assign idle_v[g]             = (st_ff == `SBC_ST_IDLE);
            assign acc_v[g]              = acc;
            assign bank_state[3*g+2:3*g] = st_ff;
            // next state per bank; others decode independently
            always @*
            begin
                nxt_st  = st_ff;
                nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
                acc     = 1'b0;
                case (st_ff)
                    `SBC_ST_IDLE:
                    begin
                        if (is_act & sel)
                        begin
                            nxt_st  = `SBC_ST_ACTV;
                            nxt_cnt = T_RCD;
                            acc     = 1'b1;
                        end
                    end
                    `SBC_ST_ACTV, `SBC_ST_PRE:
                    begin
                        if (cnt_ff <= 8'h01)
                            nxt_st = (st_ff == `SBC_ST_ACTV) ? `SBC_ST_ROW : `SBC_ST_IDLE;
                    end
                    `SBC_ST_ROW, `SBC_ST_RD, `SBC_ST_WR:
                    begin
                        // burst completion returns to row active
                        if (st_ff != `SBC_ST_ROW && cnt_ff <= 8'h01)
                            nxt_st = `SBC_ST_ROW;
                        if (is_bst && st_ff == `SBC_ST_RD && last_rd_ff == BANK_W[1:0])
                        begin
                            nxt_st  = `SBC_ST_ROW;
                            nxt_cnt = 8'h00;
                            acc     = 1'b1;
                        end
                        if ((is_rd | is_wr) & sel)
                        begin
                            acc     = 1'b1;
                            nxt_st  = is_rd ? (ap ? `SBC_ST_RDA : `SBC_ST_RD)
                                            : (ap ? `SBC_ST_WRA : `SBC_ST_WR);
                            // auto-precharge access ends at burst end or write recovery
                            nxt_cnt = is_rd ? burst_cyc : burst_cyc + (ap ? T_WR : 8'h00);
                        end
                        if (is_pre & (sel | ap))
                        begin
                            nxt_st  = `SBC_ST_PRE;
                            nxt_cnt = T_RP;
                            acc     = 1'b1;
                        end
                    end
                    `SBC_ST_RDA, `SBC_ST_WRA:
                    begin
                        if (cnt_ff <= 8'h01)
                        begin
                            nxt_st  = `SBC_ST_PRE;
                            nxt_cnt = T_RP;
                        end
                    end
                    default:
                    begin
                        nxt_st = `SBC_ST_IDLE;
                    end
                endcase
                if (is_pre & ap & (st_ff == `SBC_ST_IDLE))
                    acc = 1'b1;
            end
            // state register and countdown
            always @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    st_ff  <= `SBC_ST_IDLE;
                    cnt_ff <= 8'h00;
                end
                else
                begin
                    st_ff  <= nxt_st;
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    endgenerate

    // ************************************************
    // device-wide operations
    // ************************************************
    wire all_idle_w = &idle_v;
    wire start_ref  = is_ref & all_idle_w;
    wire start_lmr  = is_lmr & all_idle_w;
    wire start_pall = is_pre & ap & all_idle_w;
    // device-wide sequencer; blocks bank commands while busy
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dev_ff     <= `SBC_DV_NORM;
            dev_cnt_ff <= 8'h00;
        end
        else
        begin
            case (dev_ff)
                `SBC_DV_NORM:
                begin
                    if (start_ref)
                    begin
                        dev_ff     <= `SBC_DV_REF;
                        dev_cnt_ff <= T_RFC;
                    end
                    else if (start_lmr)
                    begin
                        dev_ff     <= `SBC_DV_MRS;
                        dev_cnt_ff <= T_MRD;
                    end
                    else if (start_pall)
                    begin
                        dev_ff     <= `SBC_DV_PALL;
                        dev_cnt_ff <= T_RP;
                    end
                end
                default:
                begin
                    if (dev_cnt_ff <= 8'h01)
                        dev_ff <= `SBC_DV_NORM;
                    dev_cnt_ff <= (dev_cnt_ff != 8'h00) ? dev_cnt_ff - 8'h01 : 8'h00;
                end
            endcase
        end
    end

    // tracks bank of most recently registered read
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            last_rd_ff <= 2'h0;
        else if (is_rd)
            last_rd_ff <= bsel;
    end

    // command accepted flag, any bank or device-wide
    always @*
    begin
        taken = (|acc_v)
              | start_ref | start_lmr;
    end
    reg taken_ff;
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            taken_ff <= 1'b0;
        else
            taken_ff <= taken;
    end

    assign device_state = dev_ff;
    assign all_idle     = all_idle_w & (dev_ff == `SBC_DV_NORM);
    assign cmd_taken    = taken_ff;
endmodule // sbc_bank_tracker
`default_nettype wire

// File: src/sbc_defs.vh
// constants for the sdram bank command tracker
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH
// command codes {cs_n, ras_n, cas_n, we_n}
`define SBC_CMD_ACT      4'h3
`define SBC_CMD_READ     4'h5
`define SBC_CMD_WRITE    4'h4
`define SBC_CMD_PRE      4'h2
`define SBC_CMD_BST      4'h6
`define SBC_CMD_AREF     4'h1
`define SBC_CMD_LMR      4'h0
// bank states
`define SBC_ST_IDLE      3'h0
`define SBC_ST_ACTV      3'h1
`define SBC_ST_ROW       3'h2
`define SBC_ST_RD        3'h3
`define SBC_ST_WR        3'h4
`define SBC_ST_RDA       3'h5
`define SBC_ST_WRA       3'h6
`define SBC_ST_PRE       3'h7
// device-wide states
`define SBC_DV_NORM      2'h0
`define SBC_DV_REF       2'h1
`define SBC_DV_MRS       2'h2
`define SBC_DV_PALL      2'h3
// default timings in cycles at 10 MHz
`define SBC_T_RP         8'h01
`define SBC_T_RCD        8'h01
`define SBC_T_RFC        8'h01
`define SBC_T_MRD        8'h02
`define SBC_T_WR         8'h01
`define SBC_BL           8'h04
`define SBC_CL           8'h03
`endif

// File: testbench/sbc_tracker_props.sv
// port assertions for the bank command tracker
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_tracker_props #(
    parameter [7:0] T_RP  = 8'h01,
    parameter [7:0] T_RCD = 8'h01,
    parameter [7:0] T_WR  = 8'h01,
    parameter [7:0] BL    = 8'h04
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // command pins
    input wire logic        clock_enable_pin,
    input wire logic        chip_select_n,
    input wire logic        row_strobe_n,
    input wire logic        column_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        bank_select_bit0,
    input wire logic        bank_select_bit1,
    input wire logic        auto_precharge_address_bit,
    // status
    input wire logic [11:0] bank_state,
    input wire logic [1:0]  device_state,
    input wire logic        all_idle,
    input wire logic        cmd_taken
);
    // pin decode and age of bank 0 in its present state
    wire  [3:0] code = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
    wire  [2:0] st0  = bank_state[2:0];
    wire        act0 = code == `SBC_CMD_ACT && !bank_select_bit0 && !bank_select_bit1;
    wire        quiet = chip_select_n || code[2:0] == 3'h7;
    logic [2:0] prev_ff;
    logic [7:0] age_ff;
    wire  [7:0] cyc  = (st0 != prev_ff) ? 8'h00 : age_ff;
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev_ff <= 3'h0;
            age_ff  <= 8'h00;
        end
        else
        begin
            prev_ff <= st0;
            age_ff  <= cyc + 8'h01;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_idle_flag: assert property (
        all_idle == (bank_state == 12'h000 && device_state == 2'h0)) else $error("idle flag");
    a_deselect_quiet: assert property ($past(quiet, 3) |-> !cmd_taken)
        else $error("taken on nop");
    a_enable_gate: assert property (
        !$past(clock_enable_pin, 3) || !$past(clock_enable_pin, 4) |-> !cmd_taken)
        else $error("taken without enable");
    a_act_latency: assert property (
        $rose(st0 == `SBC_ST_ACTV) |-> $past(act0 && clock_enable_pin, 3))
        else $error("activate without command");
    a_act_time: assert property (st0 == `SBC_ST_ACTV |=>
        (($past(cyc) < T_RCD - 1) ? st0 == `SBC_ST_ACTV : st0 == `SBC_ST_ROW))
        else $error("activate time");
    a_pre_time: assert property (st0 == `SBC_ST_PRE |=>
        (($past(cyc) < T_RP - 1) ? st0 == `SBC_ST_PRE : st0 == `SBC_ST_IDLE))
        else $error("precharge time");
    a_rda_time: assert property (st0 == `SBC_ST_RDA |=>
        (($past(cyc) < BL / 2 - 1) ? st0 == `SBC_ST_RDA : st0 == `SBC_ST_PRE))
        else $error("read ap time");
    a_wra_time: assert property (st0 == `SBC_ST_WRA |=>
        (($past(cyc) < BL / 2 + T_WR - 1) ? st0 == `SBC_ST_WRA : st0 == `SBC_ST_PRE))
        else $error("write ap time");
    a_act_taken: assert property ($rose(st0 == `SBC_ST_ACTV) |-> cmd_taken)
        else $error("activate not flagged");
    a_dev_banks_idle: assert property (device_state != 2'h0 |-> bank_state == 12'h000)
        else $error("bank busy in device op");
endmodule // sbc_tracker_props
bind sbc_bank_tracker sbc_tracker_props #(.T_RP(T_RP), .T_RCD(T_RCD), .T_WR(T_WR), .BL(BL))
    sbc_tracker_props_inst (.*);
`default_nettype wire

// File: testbench/sbc_ctrl_model.sv
// controller model driving the command pins
`timescale 1ns/100ps
`default_nettype none
module sbc_ctrl_model (
    // requests from the bench
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic       cke,
    input  wire logic [6:0] cmd,
    // command pins
    output var  logic       clock_enable_pin,
    output wire logic       chip_select_n,
    output wire logic       row_strobe_n,
    output wire logic       column_strobe_n,
    output wire logic       write_strobe_n,
    output wire logic       bank_select_bit1,
    output wire logic       bank_select_bit0,
    output wire logic       auto_precharge_address_bit
);
    logic [6:0] pin_ff = 7'h78;
    assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n, bank_select_bit1,
            bank_select_bit0, auto_precharge_address_bit} = pin_ff;
    // one command per edge; deselected lines toggle so no stale value lingers
    always @(posedge core_clk)
    begin
        clock_enable_pin <= cke;
        pin_ff           <= go ? cmd : {1'b1, ~pin_ff[5:0]};
    end
endmodule // sbc_ctrl_model
`default_nettype wire

// File: testbench/sbc_bank_tracker_bench.sv
// self-checking bench for the bank command tracker
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_bank_tracker_bench;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic        go       = 1'b0;
    logic        cke      = 1'b1;
    logic [6:0]  cmd      = 7'h78;
    wire         clock_enable_pin, chip_select_n, row_strobe_n, column_strobe_n;
    wire         write_strobe_n, bank_select_bit0, bank_select_bit1;
    wire         auto_precharge_address_bit, all_idle, cmd_taken;
    wire  [11:0] bank_state;
    wire  [1:0]  device_state;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          clk_count  = 0;
    int          taken      = 0;
    sbc_ctrl_model sbc_ctrl_model_inst (.*);
    sbc_bank_tracker #(.T_RCD(8'h02), .T_RP(8'h02), .T_RFC(8'h03), .BL(8'h08))
        sbc_bank_tracker_inst (.*);
    // clock, cycle ceiling and accepted-command count
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        clk_count++;
        taken <= taken + int'(cmd_taken === 1'b1);
        if (clk_count == 2000)
        begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // one command for one edge, then wait wt edges and compare bank states when wt is non-zero
    task automatic issue(input logic [3:0] code, input logic [1:0] bank, input logic ap,
                         input int wt, input logic [11:0] exp);
    begin
        @(posedge core_clk);
        go  <= 1'b1;
        cmd <= {code, bank, ap};
        @(posedge core_clk);
        go  <= 1'b0;
        repeat (wt) @(posedge core_clk);
        @(negedge core_clk);
        if (wt != 0)
            chk(bank_state, exp);
    end
    endtask
    // bursts, terminate and truncating precharge; the terminate and precharge checks land right after the change
    task automatic t_bursts;
    begin
        issue(`SBC_CMD_ACT, 2'h0, 1'b0, 0, 12'h000);
        issue(`SBC_CMD_ACT, 2'h1, 1'b0, 12, 12'h012);
        issue(`SBC_CMD_READ, 2'h1, 1'b0, 0, 12'h000);
        issue(`SBC_CMD_BST, 2'h3, 1'b0, 3, 12'h012);
        issue(`SBC_CMD_READ, 2'h0, 1'b0, 0, 12'h000);
        issue(`SBC_CMD_READ, 2'h0, 1'b0, 6, 12'h013);
        issue(`SBC_CMD_BST, 2'h0, 1'b0, 0, 12'h000);
        issue(`SBC_CMD_WRITE, 2'h0, 1'b0, 0, 12'h000);
        issue(`SBC_CMD_PRE, 2'h0, 1'b0, 3, 12'h017);
        $display("test bursts done");
    end
    endtask
    // auto precharge accesses and precharge of several banks
    task automatic t_autopre;
    begin
        issue(`SBC_CMD_READ, 2'h0, 1'b1, 12, 12'h010);
        issue(`SBC_CMD_READ, 2'h1, 1'b1, 12, 12'h000);
        issue(`SBC_CMD_ACT, 2'h0, 1'b0, 12, 12'h002);
        issue(`SBC_CMD_WRITE, 2'h0, 1'b1, 12, 12'h000);
        issue(`SBC_CMD_ACT, 2'h2, 1'b0, 12, 12'h080);
        issue(`SBC_CMD_ACT, 2'h1, 1'b0, 12, 12'h090);
        issue(`SBC_CMD_PRE, 2'h0, 1'b1, 12, 12'h000);
        $display("test auto precharge done");
    end
    endtask
    // refresh and mode load, each flagged once as accepted
    task automatic t_device;
        int n;
    begin
        n = taken;
        issue(`SBC_CMD_AREF, 2'h0, 1'b0, 5, 12'h000);
        chk({10'h000, device_state}, 12'h001);
        issue(`SBC_CMD_LMR, 2'h0, 1'b0, 3, 12'h000);
        chk({10'h000, device_state}, 12'h002);
        repeat (4) @(posedge core_clk);
        chk({11'h000, all_idle}, 12'h001);
        chk(12'(taken - n), 12'h002);
        $display("test device modes done");
    end
    endtask
    task automatic t_refuse;
        int n;
    begin
        n = taken;
        issue(`SBC_CMD_READ, 2'h3, 1'b0, 12, 12'h000);
        @(posedge core_clk);
        cke <= 1'b0;
        issue(`SBC_CMD_ACT, 2'h0, 1'b0, 12, 12'h000);
        chk(12'(taken - n), 12'h000);
        $display("test refusals done");
    end
    endtask
    task automatic results;
    begin
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk);
        chk({device_state, all_idle, bank_state[8:0]}, 12'h200);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_bursts();
        t_autopre();
        t_device();
        t_refuse();
        results();
    end
endmodule // sbc_bank_tracker_bench
`default_nettype wire
